//--- pkg/rsi_pkg.sv
// Package for the reset state initialiser: constants, states and carrier structs
package rsi_pkg;
  localparam logic [15:0] VEC_ADDR_LO  = 16'h0000;
  localparam logic [15:0] VEC_ADDR_HI  = 16'h0001;
  localparam logic [7:0]  STATUS_RESET = 8'h06;
  localparam logic [15:0] PC_UNDEF     = 16'h0000;
  localparam int          SYNC_STAGES  = 2;
  localparam int          CLK_HZ       = 20_000_000;
  // Oscillation settle wait, in microseconds (plain default)
  localparam int          OSC_WAIT_US  = 10;
  localparam int          OSC_WAIT_CYC = (OSC_WAIT_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                         OSC_WAIT_US * (CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    RSI_HOLD    = 3'b000,
    RSI_SETTLE  = 3'b001,
    RSI_FETCHLO = 3'b011,
    RSI_FETCHHI = 3'b010,
    RSI_RUN     = 3'b110
  } rsi_state_t;

  // Internal reset sources
  typedef struct packed {
    logic watchdog;
    logic illegalInstr;
    logic parityErr;
    logic illegalAccess;
    logic supplyMonitor;
  } rsi_src_t;

  // Vector fetch request to memory
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } rsi_fetch_t;

  // CPU state loaded at reset acknowledgment
  typedef struct packed {
    logic        valid;
    logic [15:0] programCounter;
    logic [7:0]  processorStatusWord;
  } rsi_cpu_t;
endpackage : rsi_pkg

//--- src/rsi_reset_state_init.sv
// Reset acknowledge logic: source merge, settle wait, vector load and status init
// Functional notes
// - Program counter loads from vector bytes at 0000H (low) and 0001H (high).
// - Processor status word is set to 06H on reset acknowledgment.
// - Supply monitor runs during its own reset, stops for any other reset.
// - Program counter is undefined during reset and the settle wait.
// - Stack pointer, RAM and general registers are not touched by reset.
// - Reset holds while the external pin is low, ends when it goes high.
// - Execution starts with the fast internal oscillator clock selected.
// - Watchdog, illegal instruction, parity and access resets self-release.
module rsi_reset_state_init #(
  parameter int OSC_WAIT_CYCLES = rsi_pkg::OSC_WAIT_CYC
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              resetPinN,
  input  wire rsi_pkg::rsi_src_t srcReq,
  input  wire logic [7:0]        fetchData,
  input  wire logic              fetchValid,
  input  wire logic [3:0]        extIrqIn,
  output rsi_pkg::rsi_fetch_t    fetchReq,
  output rsi_pkg::rsi_cpu_t      cpuInit,
  output logic                   cpuHalt,
  output logic                   supplyMonitorEnable,
  output logic                   fastInternalOscSelect,
  output logic [3:0]             extIrqOut
);
  localparam int CW = $clog2(OSC_WAIT_CYCLES + 1);

  // Pin synchroniser, first stage read only by the second
  logic pinSync1_reg;
  logic pinSync2_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
    end else begin
      pinSync1_reg <= resetPinN;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // Self-releasing source pulses are latched so a one-cycle request still gives a full reset
  logic       supplyRst_reg;
  logic       selfRst_reg;
  wire  logic selfReq   = srcReq.watchdog | srcReq.illegalInstr |
                          srcReq.parityErr | srcReq.illegalAccess;
  wire  logic pinActive = !pinSync2_reg;

  rsi_pkg::rsi_state_t state_reg;
  rsi_pkg::rsi_state_t state_next;
  logic [CW-1:0]       waitCnt_reg;
  logic [7:0]          pcLo_reg;
  rsi_pkg::rsi_cpu_t   cpu_reg;
  rsi_pkg::rsi_fetch_t fetch_reg;

  wire logic waitDone = (waitCnt_reg == CW'(OSC_WAIT_CYCLES - 1));
  // Supply leaves HOLD on its own request edge, so the monitor never drops at the tail
  wire logic anyReset = pinActive | selfRst_reg | selfReq | srcReq.supplyMonitor;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supplyRst_reg <= 1'b0;
      selfRst_reg   <= 1'b0;
    end else begin
      // Supply reset lasts as long as the monitor reports low voltage
      supplyRst_reg <= srcReq.supplyMonitor;
      // Self-releasing: stretches HOLD by one cycle after the request, then clears
      if (selfReq)
        selfRst_reg <= 1'b1;
      else if (state_reg == rsi_pkg::RSI_HOLD)
        selfRst_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsi_pkg::RSI_HOLD:    if (!anyReset) state_next = rsi_pkg::RSI_SETTLE;
      rsi_pkg::RSI_SETTLE:  if (waitDone) state_next = rsi_pkg::RSI_FETCHLO;
      rsi_pkg::RSI_FETCHLO: if (fetchValid) state_next = rsi_pkg::RSI_FETCHHI;
      rsi_pkg::RSI_FETCHHI: if (fetchValid) state_next = rsi_pkg::RSI_RUN;
      rsi_pkg::RSI_RUN:     state_next = rsi_pkg::RSI_RUN;
      default:              state_next = rsi_pkg::RSI_HOLD;
    endcase
    if (anyReset)
      state_next = rsi_pkg::RSI_HOLD;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= rsi_pkg::RSI_HOLD;
      waitCnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      waitCnt_reg <= (state_reg == rsi_pkg::RSI_SETTLE) ? waitCnt_reg + CW'(1) : '0;
    end
  end

  wire logic fetchLo = (state_next == rsi_pkg::RSI_FETCHLO);
  wire logic fetchHi = (state_next == rsi_pkg::RSI_FETCHHI);
  wire logic nextRun = (state_next == rsi_pkg::RSI_RUN);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fetch_reg <= '0;
    end else begin
      fetch_reg.rd   <= fetchLo | fetchHi;
      fetch_reg.addr <= fetchHi ? rsi_pkg::VEC_ADDR_HI : rsi_pkg::VEC_ADDR_LO;
    end
  end

  // Only PC and PROCESSOR_STATUS_WORD are driven; SP, RAM and GPRs have no path from here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pcLo_reg <= '0;
      cpu_reg  <= '0;
    end else if (!nextRun) begin
      // Cleared on the HOLD edge itself, so a stale vector never shows in reset
      cpu_reg.valid          <= 1'b0;
      cpu_reg.programCounter <= rsi_pkg::PC_UNDEF;
      if (state_reg == rsi_pkg::RSI_FETCHLO && fetchValid)
        pcLo_reg <= fetchData;
    end else if (state_reg == rsi_pkg::RSI_FETCHHI) begin
      cpu_reg.valid               <= 1'b1;
      cpu_reg.programCounter      <= {fetchData, pcLo_reg};
      cpu_reg.processorStatusWord <= rsi_pkg::STATUS_RESET;
    end
  end

  // Interrupt pins are asynchronous: two stages, then gated into a register
  logic [3:0] irqSync1_reg;
  logic [3:0] irqSync2_reg;
  logic [3:0] irqOut_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqSync1_reg <= '0;
      irqSync2_reg <= '0;
      irqOut_reg   <= '0;
    end else begin
      irqSync1_reg <= extIrqIn;
      irqSync2_reg <= irqSync1_reg;
      irqOut_reg   <= nextRun ? irqSync2_reg : '0;
    end
  end

  assign fetchReq  = fetch_reg;
  assign cpuInit   = cpu_reg;
  assign cpuHalt   = (state_reg != rsi_pkg::RSI_RUN);
  // Monitor off for non-supply resets; a supply reset must keep watching VDD
  assign supplyMonitorEnable   = !(state_reg == rsi_pkg::RSI_HOLD) | supplyRst_reg;
  assign fastInternalOscSelect = (state_reg == rsi_pkg::RSI_RUN);
  assign extIrqOut = irqOut_reg;

endmodule // rsi_reset_state_init

//--- dv/rsi_reset_state_init_assertions.sv
// Port checker for the reset state initialiser
module rsi_reset_state_init_assertions (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                resetPinN,
  input wire logic                fetchValid,
  input wire logic                cpuHalt,
  input wire logic                supplyMonitorEnable,
  input wire logic                fastInternalOscSelect,
  input wire logic [7:0]          fetchData,
  input wire logic [3:0]          extIrqIn,
  input wire logic [3:0]          extIrqOut,
  input wire rsi_pkg::rsi_src_t   srcReq,
  input wire rsi_pkg::rsi_fetch_t fetchReq,
  input wire rsi_pkg::rsi_cpu_t   cpuInit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_irq_gated: assert property (cpuHalt |-> extIrqOut == 4'h0) else $error("irq leaks");
  a_pc_undef: assert property (!cpuInit.valid |-> cpuInit.programCounter == 16'h0000)
    else $error("pc defined early");
  a_psw_value: assert property (cpuInit.valid |-> cpuInit.processorStatusWord == 8'h06)
    else $error("psw wrong");
  a_fetch_first: assert property ($rose(fetchReq.rd) |-> fetchReq.addr == 16'h0000)
    else $error("first fetch addr");
  a_fetch_next: assert property (fetchValid && fetchReq.rd && fetchReq.addr == 16'h0000
    && srcReq == '0 && $past(resetPinN, 2)
    |=> fetchReq.rd && fetchReq.addr == 16'h0001) else $error("second fetch addr");
  a_pc_high: assert property (fetchValid && fetchReq.rd && fetchReq.addr == 16'h0001 |=>
    cpuInit.valid && cpuInit.programCounter[15:8] == $past(fetchData)) else $error("pc high");
  a_pin_holds: assert property (!resetPinN |-> ##4 cpuHalt) else $error("pin ignored");
  a_mon_keep: assert property ($past(srcReq.supplyMonitor) && srcReq.supplyMonitor
    |-> supplyMonitorEnable) else $error("monitor stopped");
  a_mon_stop: assert property (srcReq.watchdog && !srcReq.supplyMonitor |=>
    !supplyMonitorEnable || srcReq.supplyMonitor) else $error("monitor running");
  a_self_release: assert property (srcReq.watchdog |-> ##[1:40] !cpuHalt)
    else $error("no self release");
  a_run_osc: assert property (!cpuHalt |-> fastInternalOscSelect && cpuInit.valid)
    else $error("run without osc");
  a_valid_halt: assert property (cpuHalt |-> !cpuInit.valid)
    else $error("pc valid in reset");
endmodule // rsi_reset_state_init_assertions
bind rsi_reset_state_init rsi_reset_state_init_assertions u_chk (.clock, .resetn, .resetPinN,
  .fetchValid, .cpuHalt, .supplyMonitorEnable, .fastInternalOscSelect, .fetchData, .extIrqIn,
  .extIrqOut, .srcReq, .fetchReq, .cpuInit);

//--- dv/rsi_vec_mem.sv
// Vector memory model answering fetches after a set latency
module rsi_vec_mem #(parameter logic [15:0] VEC = 16'hB7E2) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic [7:0]          lat,
  input  wire rsi_pkg::rsi_fetch_t fetchReq,
  output logic [7:0]               fetchData,
  output logic                     fetchValid
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00; fetchValid <= 1'b0; fetchData <= 8'h5A;
    end else if (fetchReq.rd && !fetchValid && cnt_reg >= lat) begin
      fetchValid <= 1'b1; cnt_reg <= 8'h00;
      fetchData <= fetchReq.addr[0] ? VEC[15:8] : VEC[7:0];
    end else begin
      // Stale data is inverted each cycle, so it returns to the last real byte every other cycle
      fetchValid <= 1'b0; fetchData <= ~fetchData;
      cnt_reg <= (fetchReq.rd && !fetchValid) ? cnt_reg + 8'h01 : 8'h00;
    end
  end
endmodule // rsi_vec_mem

//--- dv/rsi_reset_state_init_tb.sv
// Self-checking bench for the reset state initialiser
module rsi_reset_state_init_tb;
  timeunit 1ns; timeprecision 1ps;
  localparam logic [15:0] VEC = 16'hB7E2;
  typedef struct {logic [4:0] src; logic pin; logic [7:0] lat; logic en;} rsi_row_t;
  logic clock = 0, resetn = 0, resetPinN = 0, fetchValid, cpuHalt, supplyMonitorEnable;
  logic fastInternalOscSelect;
  logic [7:0] fetchData, lat = 8'h00;
  logic [3:0] extIrqIn = 4'hA, extIrqOut;
  rsi_pkg::rsi_src_t srcReq = '0;
  rsi_pkg::rsi_fetch_t fetchReq;
  rsi_pkg::rsi_cpu_t cpuInit;
  int err_total = 0, compares = 0, n;
  rsi_row_t rows[6] = '{'{5'h10, 1'b0, 8'h00, 1'b0}, '{5'h08, 1'b0, 8'h01, 1'b0},
    '{5'h04, 1'b0, 8'h02, 1'b0}, '{5'h02, 1'b0, 8'h03, 1'b0},
    '{5'h01, 1'b0, 8'h04, 1'b1}, '{5'h00, 1'b1, 8'h05, 1'b0}};
  always #25 clock = ~clock;
  rsi_reset_state_init #(.OSC_WAIT_CYCLES(4)) DUT (.clock, .resetn, .resetPinN, .srcReq,
    .fetchData, .fetchValid, .extIrqIn, .fetchReq, .cpuInit, .cpuHalt, .supplyMonitorEnable,
    .fastInternalOscSelect, .extIrqOut);
  rsi_vec_mem #(.VEC(VEC)) u_mem (.clock, .resetn, .lat, .fetchReq, .fetchData, .fetchValid);
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++; $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run_check();
    for (n = 0; n < 80 && cpuHalt !== 1'b0; n++) @(negedge clock);
    chk("released", n < 80, 1'b1);
    if (n >= 80) conclude();
    chk("pc", cpuInit.programCounter, VEC);
    chk("psw", cpuInit.processorStatusWord, 8'h06);
    chk("osc", fastInternalOscSelect, 1'b1);
    chk("irqPass", extIrqOut, extIrqIn);
  endtask
  initial begin
    repeat (5) @(negedge clock);
    chk("haltInReset", cpuHalt, 1'b1);
    resetn = 1'b1;
    foreach (rows[i]) begin
      srcReq = rows[i].src; resetPinN = ~rows[i].pin; lat = rows[i].lat;
      repeat (4) @(negedge clock);
      chk("monEn", supplyMonitorEnable, rows[i].en);
      chk("irqOut", extIrqOut, 4'h0);
      chk("pcUndef", cpuInit.programCounter, 16'h0000);
      srcReq = '0; resetPinN = 1'b1;
      @(negedge clock);
      chk("monTail", supplyMonitorEnable, rows[i].en);
      run_check();
    end
    // Second source arriving mid-fetch must restart the whole sequence
    lat = 8'h06; srcReq.watchdog = 1'b1;
    @(negedge clock) srcReq = '0;
    for (n = 0; n < 40 && fetchReq.rd !== 1'b1; n++) @(negedge clock);
    chk("fetchSeen", n < 40, 1'b1);
    if (n >= 40) conclude();
    srcReq.parityErr = 1'b1;
    @(negedge clock) srcReq = '0;
    chk("pcMidFetch", cpuInit.valid, 1'b0);
    run_check();
    // Power reset in mid-run: back to the reset picture, then a clean restart
    extIrqIn = 4'h5;
    resetn = 1'b0;
    @(negedge clock);
    chk("haltMidReset", cpuHalt, 1'b1);
    chk("validMidReset", cpuInit.valid, 1'b0);
    chk("monMidReset", supplyMonitorEnable, 1'b0);
    chk("irqMidReset", extIrqOut, 4'h0);
    resetn = 1'b1;
    run_check();
    conclude();
  end
endmodule // rsi_reset_state_init_tb
